// *** common/sasw_pkg.sv ***
// Purpose: Shared constants and types for the security attribution block
// Assumes: APB4 register bus, 32-bit data, word-aligned registers
// Notes:   Register offsets are byte addresses within the block
package sasw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_TYPE  = 8'h04;
  localparam logic [7:0] OFF_RSEL  = 8'h08;
  localparam logic [7:0] OFF_RBASE = 8'h0c;
  localparam logic [7:0] OFF_RLIM  = 8'h10;
  localparam logic [7:0] OFF_ITGT  = 8'h14;

  // Field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_ALL_NON_SECURE_BIT_BIT = 1;
  localparam int LIM_EN_BIT     = 0;
  localparam int LIM_NSC_BIT    = 1;
  localparam int ADDR_LO        = 5;
  localparam int SEL_W          = 8;
  localparam int PROT_NS_BIT    = 1;

  // Sizes and reset values
  localparam int MAX_REGIONS = 8;
  localparam int NUM_IRQ     = 32;
  localparam int IRQ_W       = 5;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [4:0]  LIM_LOW    = 5'h1f;
  localparam logic [SEL_W-1:0] SEL_RESET = 8'h00;

  // Marker loaded into the link register on a call out
  localparam logic [31:0] RET_MARKER = 32'hfeff_fffe;

  // Memory attribute of an address
  typedef enum logic [1:0] {
    ATTR_SECURE,
    ATTR_CALLABLE,
    ATTR_NONSECURE
  } sasw_attr_e;

  // Kind of control transfer that produced a fetch
  typedef enum logic [1:0] {
    FK_SEQ,
    FK_BRANCH,
    FK_BR_NS,
    FK_CALL_NS
  } sasw_fkind_e;

  typedef struct packed {
    logic        valid;
    sasw_fkind_e kind;
    logic        is_gateway;
    logic [31:0] addr;
  } sasw_fetch_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } sasw_data_s;

  typedef struct packed {
    logic             valid;
    logic [IRQ_W-1:0] num;
    logic             secure_fp_used;
    logic             handler_fp_used;
  } sasw_irq_s;

  // Registered one-cycle event outputs toward the core
  typedef struct packed {
    logic fault;
    logic fault_hard;
    logic push_ret;
    logic pop_ret;
    logic lr_load;
    logic full_push;
    logic clear_bank;
    logic fp_stack;
    logic irq_to_ns;
    logic data_fault;
    logic data_ns;
  } sasw_evt_s;

endpackage

// *** core/sasw_core.sv ***
// Purpose: Security attribution table and secure/non-secure switch checker
// Assumes: Core-side inputs are synchronous to pclk; APB4 with pprot
// Notes:   Zero-wait APB slave, read data captured in the setup phase
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module sasw_core
  import sasw_pkg::*;
#(
  parameter int NUM_REGIONS  = 8,
  parameter bit HAS_MAIN_EXT = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [2:0]  pprot,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire sasw_fetch_s fetch,
  input  wire sasw_data_s  data,
  input  wire sasw_irq_s   irq,
  output logic             secure_state,
  output logic [31:0]      link_value,
  output sasw_evt_s        evt
);

  // ---------------- APB decode ----------------
  wire setup_ph = psel & ~penable;
  wire access   = psel & penable;
  wire ns_bus   = pprot[PROT_NS_BIT];
  wire hit_ctrl = (paddr == OFF_CTRL);
  wire hit_type = (paddr == OFF_TYPE);
  wire hit_sel  = (paddr == OFF_RSEL);
  wire hit_base = (paddr == OFF_RBASE);
  wire hit_lim  = (paddr == OFF_RLIM);
  wire hit_itgt = (paddr == OFF_ITGT);
  wire mapped   = hit_ctrl | hit_type | hit_sel | hit_base | hit_lim
                | hit_itgt;
  // Non-secure writes are dropped silently
  wire wr_ok    = access & pwrite & mapped & ~ns_bus;
  wire full_wr  = &pstrb; // Partial writes ignored, fields span lanes

  // Control and selection state
  logic                  en_q;
  logic                  all_non_secure_bit_q;
  logic [SEL_W-1:0]      sel_q;
  logic [NUM_IRQ-1:0]    itgt_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;

  wire sel_valid = ({24'h000000, sel_q} < 32'(NUM_REGIONS));

  // Per-region storage, one word each
  logic [31:ADDR_LO] base_q [MAX_REGIONS];
  logic [31:ADDR_LO] lim_q  [MAX_REGIONS];
  logic              nsc_q  [MAX_REGIONS];
  logic              ren_q  [MAX_REGIONS];

  // Per-region hit flags for fetch and data
  logic [MAX_REGIONS-1:0] f_hit;
  logic [MAX_REGIONS-1:0] f_nsc;
  logic [MAX_REGIONS-1:0] d_hit;
  logic [MAX_REGIONS-1:0] d_nsc;

  // ---------------- Region table ----------------
  genvar gi;
  generate
    for (gi = 0; gi < MAX_REGIONS; gi++) begin : g_reg
      localparam bit IMPL = (gi < NUM_REGIONS);
      wire sel_me = (sel_q == SEL_W'(gi));
      wire wr_b   = IMPL & wr_ok & full_wr & hit_base & sel_me;
      wire wr_l   = IMPL & wr_ok & full_wr & hit_lim & sel_me;
      wire [31:0] lim_full = {lim_q[gi], LIM_LOW};

      // Region registers; unimplemented slots stay cleared
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          base_q[gi] <= '0;
          lim_q[gi]  <= '0;
          nsc_q[gi]  <= 1'b0;
          ren_q[gi]  <= 1'b0;
        end else begin
          if (wr_b) begin
            base_q[gi] <= pwdata[31:ADDR_LO];
          end
          if (wr_l) begin
            lim_q[gi] <= pwdata[31:ADDR_LO];
            nsc_q[gi] <= pwdata[LIM_NSC_BIT];
            ren_q[gi] <= pwdata[LIM_EN_BIT];
          end
        end
      end

      // Inclusive range match; overlap is not arbitrated
      assign f_hit[gi] = ren_q[gi]
        & (fetch.addr[31:ADDR_LO] >= base_q[gi])
        & (fetch.addr <= lim_full);
      assign d_hit[gi] = ren_q[gi]
        & (data.addr[31:ADDR_LO] >= base_q[gi])
        & (data.addr <= lim_full);
      assign f_nsc[gi] = f_hit[gi] & nsc_q[gi];
      assign d_nsc[gi] = d_hit[gi] & nsc_q[gi];
    end
  endgenerate

  // ---------------- Attribution ----------------
  sasw_attr_e f_attr;
  sasw_attr_e d_attr;
  sasw_attr_e off_attr;

  // Disabled unit follows the all-non-secure bit
  assign off_attr = all_non_secure_bit_q ? ATTR_NONSECURE : ATTR_SECURE;

  always_comb begin
    if (!en_q) begin
      f_attr = off_attr;
    end else if (|f_nsc) begin
      f_attr = ATTR_CALLABLE;
    end else if (|f_hit) begin
      f_attr = ATTR_NONSECURE;
    end else begin
      f_attr = ATTR_SECURE;
    end
  end

  always_comb begin
    if (!en_q) begin
      d_attr = off_attr;
    end else if (|d_nsc) begin
      d_attr = ATTR_CALLABLE;
    end else if (|d_hit) begin
      d_attr = ATTR_NONSECURE;
    end else begin
      d_attr = ATTR_SECURE;
    end
  end

  // ---------------- Register read mux ----------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = ZERO_WORD;
    if (hit_ctrl) begin
      rd_word[CTRL_EN_BIT]    = en_q;
      rd_word[CTRL_ALL_NON_SECURE_BIT_BIT] = all_non_secure_bit_q;
    end else if (hit_type) begin
      rd_word[SEL_W-1:0] = SEL_W'(NUM_REGIONS);
    end else if (hit_sel) begin
      rd_word[SEL_W-1:0] = sel_q;
    end else if (hit_base && sel_valid) begin
      rd_word[31:ADDR_LO] = base_q[sel_q[2:0]];
    end else if (hit_lim && sel_valid) begin
      rd_word[31:ADDR_LO]   = lim_q[sel_q[2:0]];
      rd_word[LIM_NSC_BIT]  = nsc_q[sel_q[2:0]];
      rd_word[LIM_EN_BIT]   = ren_q[sel_q[2:0]];
    end else if (hit_itgt) begin
      rd_word = itgt_q;
    end
    if (ns_bus) begin
      rd_word = ZERO_WORD;
    end
  end

  // Read data caught in setup so the answer leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= ZERO_WORD;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q  <= pwrite ? ZERO_WORD : rd_word;
      pslverr_q <= ~mapped;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & access;

  // Control, select and interrupt target registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q    <= 1'b0;
      all_non_secure_bit_q <= 1'b0;
      sel_q   <= SEL_RESET;
      itgt_q  <= '0;
    end else if (wr_ok && full_wr) begin
      if (hit_ctrl) begin
        en_q    <= pwdata[CTRL_EN_BIT];
        all_non_secure_bit_q <= pwdata[CTRL_ALL_NON_SECURE_BIT_BIT];
      end
      if (hit_sel) begin
        sel_q <= pwdata[SEL_W-1:0];
      end
      if (hit_itgt) begin
        itgt_q <= pwdata;
      end
    end
  end

  // ---------------- State switch checker ----------------
  logic      sec_q;
  logic      sec_d;
  sasw_evt_s evt_q;
  sasw_evt_s evt_d;
  logic [31:0] link_q;
  logic [31:0] link_d;

  wire f_ns     = (f_attr == ATTR_NONSECURE);
  wire f_call   = (f_attr == ATTR_CALLABLE);
  wire to_ns_op = (fetch.kind == FK_BR_NS) | (fetch.kind == FK_CALL_NS);
  wire is_mark  = (fetch.addr == RET_MARKER);
  wire irq_ns   = itgt_q[irq.num];

  // Interrupt entry wins over a fetch in the same cycle
  always_comb begin
    sec_d  = sec_q;
    evt_d  = '0;
    link_d = link_q;
    if (irq.valid) begin
      evt_d.irq_to_ns = irq_ns;
      if (irq_ns && sec_q) begin
        evt_d.full_push  = 1'b1;
        evt_d.clear_bank = 1'b1;
        // FP context only stacked when the handler needs it
        evt_d.fp_stack   = irq.secure_fp_used
                         & irq.handler_fp_used;
        sec_d = 1'b0;
      end else if (!irq_ns && !sec_q) begin
        sec_d = 1'b1;
      end
    end else if (fetch.valid) begin
      if (sec_q) begin
        if (to_ns_op && f_ns) begin
          if (fetch.kind == FK_CALL_NS && fetch.addr[0]) begin
            evt_d.fault      = 1'b1;
            evt_d.fault_hard = ~HAS_MAIN_EXT;
          end else begin
            sec_d = 1'b0;
            if (fetch.kind == FK_CALL_NS) begin
              evt_d.push_ret = 1'b1;
              evt_d.lr_load  = 1'b1;
              link_d         = RET_MARKER;
            end
          end
        end else if (f_ns) begin
          // Falling into Non-secure code needs an explicit switch
          evt_d.fault      = 1'b1;
          evt_d.fault_hard = ~HAS_MAIN_EXT;
        end
      end else begin
        if (is_mark) begin
          evt_d.pop_ret = 1'b1;
          sec_d = 1'b1;
        end else if (f_call && fetch.is_gateway) begin
          sec_d = 1'b1;
        end else if (!f_ns) begin
          evt_d.fault      = 1'b1;
          evt_d.fault_hard = ~HAS_MAIN_EXT;
        end
      end
    end
    if (data.valid) begin
      evt_d.data_fault = ~sec_q
                       & (d_attr != ATTR_NONSECURE);
      evt_d.data_ns    = (d_attr == ATTR_NONSECURE);
    end
  end

  // Core comes out of reset in Secure state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q  <= 1'b1;
      evt_q  <= '0;
      link_q <= ZERO_WORD;
    end else begin
      sec_q  <= sec_d;
      evt_q  <= evt_d;
      link_q <= link_d;
    end
  end

  assign secure_state = sec_q;
  assign link_value   = link_q;
  assign evt          = evt_q;

endmodule // sasw_core

`default_nettype wire

// *** verif/sasw_core_checker.sv ***
// Purpose: Port assertions for the attribution and state switch core
// Assumes: One pclk domain, presetn async active low
// Notes:   Bound to every core instance
`timescale 1ns/10ps
`default_nettype none
module sasw_core_checker
  import sasw_pkg::*;
#(
  parameter bit HAS_MAIN_EXT = 1'b1
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire sasw_fetch_s fetch,
  input wire sasw_data_s  data,
  input wire sasw_irq_s   irq,
  input wire logic        secure_state,
  input wire logic [31:0] link_value,
  input wire sasw_evt_s   evt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Fetches that count; an interrupt in the same cycle wins
  sequence s_call_odd;
    secure_state && fetch.valid && !irq.valid &&
    fetch.kind == FK_CALL_NS && fetch.addr[0];
  endsequence
  sequence s_ret;
    !secure_state && fetch.valid && !irq.valid && fetch.addr == RET_MARKER;
  endsequence

  property p_call_odd;
    s_call_odd |=> evt.fault && !evt.push_ret;
  endproperty
  a_call_odd: assert property (p_call_odd)
    else $error("odd call target not refused");
  property p_push;
    evt.push_ret |-> evt.lr_load && link_value == RET_MARKER && !secure_state;
  endproperty
  a_push: assert property (p_push)
    else $error("call out without marker or state change");
  property p_ret;
    s_ret |=> evt.pop_ret && secure_state;
  endproperty
  a_ret: assert property (p_ret)
    else $error("marker branch did not resume secure caller");
  property p_fault;
    evt.fault |-> evt.fault_hard == !HAS_MAIN_EXT && $stable(secure_state);
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault kind wrong or state moved");
  // Secure state is only regained through a gateway, marker or interrupt
  property p_gate;
    $rose(secure_state) |-> $past(irq.valid || fetch.valid &&
      (fetch.is_gateway || fetch.addr == RET_MARKER));
  endproperty
  a_gate: assert property (p_gate)
    else $error("secure state entered without valid entry");
  property p_irq;
    // Only a crossing out of Secure state needs the full push
    evt.irq_to_ns && $past(secure_state) |->
      evt.full_push && evt.clear_bank && !secure_state &&
      evt.fp_stack == $past(irq.secure_fp_used && irq.handler_fp_used);
  endproperty
  a_irq: assert property (p_irq)
    else $error("non-secure interrupt entry incomplete");
  property p_data;
    data.valid && !secure_state |=> evt.data_fault != evt.data_ns;
  endproperty
  a_data: assert property (p_data)
    else $error("non-secure data access neither marked nor faulted");
  property p_ns_read;
    psel && !penable && !pwrite && pprot[PROT_NS_BIT] |=>
      prdata == ZERO_WORD;
  endproperty
  a_ns_read: assert property (p_ns_read)
    else $error("non-secure register read not zero");
endmodule // sasw_core_checker

bind sasw_core sasw_core_checker #(.HAS_MAIN_EXT(HAS_MAIN_EXT)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pprot(pprot), .prdata(prdata), .fetch(fetch),
  .data(data), .irq(irq), .secure_state(secure_state),
  .link_value(link_value), .evt(evt));
`default_nettype wire

// *** verif/sasw_core_tb.sv ***
// Purpose: Self-checking bench for the attribution and state switch core
// Assumes: Zero-wait APB slave, core events one edge after the request
// Notes:   Secure register access unless a test asks otherwise
`timescale 1ns/10ps
`default_nettype none
module sasw_core_tb
  import sasw_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  pprot = 3'h0;
  logic        pready, pslverr, secure_state, err;
  logic [31:0] prdata, link_value, rd;
  sasw_fetch_s fetch;
  sasw_data_s  data;
  sasw_irq_s   irq;
  sasw_evt_s   evt;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;

  sasw_core #(.NUM_REGIONS(8), .HAS_MAIN_EXT(1'b1)) sasw_core_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .fetch(fetch), .data(data), .irq(irq), .secure_state(secure_state),
    .link_value(link_value), .evt(evt));
  sasw_cpu_model sasw_cpu_model_i (
    .pclk(pclk), .fetch(fetch), .data(data), .irq(irq));

  always #50 pclk = ~pclk;
  // Hang guard, far above the roughly 125 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Held until pready is seen high at an edge, released after it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic ns);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic ns,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, ns);
    chk(n, e, rd);
  endtask
  task automatic cpu_go(input int w, input sasw_fkind_e k, input logic g,
                        input logic [31:0] a);
    sasw_cpu_model_i.go(w, k, g, a);
    #1;
  endtask
  task automatic dchk(input logic [31:0] a, input logic ns, f);
    cpu_go(1, FK_SEQ, 1'b0, a);
    chk("data_ns", ns, evt.data_ns);
    chk("data_fault", f, evt.data_fault);
  endtask

  task automatic t_regs();
    rdc("ctrl", OFF_CTRL, 1'b0, 32'h0);
    rdc("type", OFF_TYPE, 1'b0, 32'h8);
    wr(OFF_RSEL, 32'hffff_ff07);
    rdc("sel", OFF_RSEL, 1'b0, 32'h7);
    wr(OFF_RBASE, 32'h1234_567f);
    rdc("base", OFF_RBASE, 1'b0, 32'h1234_5660);
    wr(OFF_RLIM, 32'hffff_fffe);
    rdc("lim ns", OFF_RLIM, 1'b1, 32'h0);
    apb(1'b1, OFF_RLIM, 32'h0, 1'b1);
    rdc("lim", OFF_RLIM, 1'b0, 32'hffff_ffe2);
    rdc("unmapped", 8'h40, 1'b0, 32'h0);
    chk("slverr", 1, err);
    $display("t_regs done");
  endtask
  task automatic t_attr();
    wr(OFF_RSEL, 32'h0);
    wr(OFF_RBASE, 32'h2020_0000);
    wr(OFF_RLIM, 32'h203f_ffe1);
    wr(OFF_RSEL, 32'h1);
    wr(OFF_RBASE, 32'h0020_0000);
    wr(OFF_RLIM, 32'h003f_ffe3);
    wr(OFF_CTRL, 32'h1);
    dchk(32'h2020_0000, 1'b1, 1'b0);
    dchk(32'h203f_ffff, 1'b1, 1'b0);
    dchk(32'h201f_ffff, 1'b0, 1'b0);
    dchk(32'h2040_0000, 1'b0, 1'b0);
    dchk(32'h0030_0000, 1'b0, 1'b0);
    dchk(32'h5000_0000, 1'b0, 1'b0);
    $display("t_attr done");
  endtask
  task automatic t_switch();
    cpu_go(0, FK_CALL_NS, 1'b0, 32'h2020_0101);
    chk("fault", 1, evt.fault);
    cpu_go(0, FK_CALL_NS, 1'b0, 32'h2020_0100);
    chk("push", 1, evt.push_ret);
    chk("lr_load", 1, evt.lr_load);
    chk("lr", RET_MARKER, link_value);
    chk("state", 0, secure_state);
    dchk(32'h0030_0000, 1'b0, 1'b1);
    cpu_go(0, FK_BRANCH, 1'b0, 32'h0020_0000);
    chk("fault", 1, evt.fault);
    chk("hard", 0, evt.fault_hard);
    cpu_go(0, FK_BRANCH, 1'b1, 32'h1000_0000);
    chk("fault", 1, evt.fault);
    cpu_go(0, FK_BRANCH, 1'b0, RET_MARKER);
    chk("pop", 1, evt.pop_ret);
    chk("state", 1, secure_state);
    cpu_go(0, FK_SEQ, 1'b0, 32'h2020_0200);
    chk("fault", 1, evt.fault);
    cpu_go(0, FK_BR_NS, 1'b0, 32'h2020_0200);
    chk("state", 0, secure_state);
    cpu_go(0, FK_BRANCH, 1'b1, 32'h0020_0040);
    chk("state", 1, secure_state);
    $display("t_switch done");
  endtask
  task automatic t_irq();
    apb(1'b1, OFF_ITGT, 32'h8, 1'b1);
    rdc("itgt", OFF_ITGT, 1'b0, 32'h0);
    wr(OFF_ITGT, 32'h8);
    rdc("itgt", OFF_ITGT, 1'b0, 32'h8);
    cpu_go(2, FK_SEQ, 1'b0, 32'h0103);
    chk("push", 1, evt.full_push);
    chk("to_ns", 1, evt.irq_to_ns);
    chk("clear", 1, evt.clear_bank);
    chk("fp", 0, evt.fp_stack);
    chk("state", 0, secure_state);
    cpu_go(2, FK_SEQ, 1'b0, 32'h0302);
    chk("state", 1, secure_state);
    cpu_go(2, FK_SEQ, 1'b0, 32'h0303);
    chk("fp", 1, evt.fp_stack);
    $display("t_irq done");
  endtask
  task automatic t_all_non_secure_bit();
    wr(OFF_CTRL, 32'h2);
    dchk(32'h0030_0000, 1'b1, 1'b0);
    wr(OFF_CTRL, 32'h0);
    dchk(32'h2020_0000, 1'b0, 1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk("state", 1, secure_state);
    chk("lr", 0, link_value);
    @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", OFF_CTRL, 1'b0, 32'h0);
    $display("t_all_non_secure_bit done");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_attr();
    t_switch();
    t_irq();
    t_all_non_secure_bit();
    finish_test();
  end
endmodule // sasw_core_tb
`default_nettype wire

// *** verif/sasw_cpu_model.sv ***
// Purpose: Core-side model issuing fetch, data and interrupt requests
// Assumes: One request per call, launched right after a rising edge
// Notes:   Idle lines carry inverted values except the fetch kind and the cleared valid bits, never the last request
`timescale 1ns/10ps
`default_nettype none
module sasw_cpu_model
  import sasw_pkg::*;
(
  input  wire logic        pclk,
  output var sasw_fetch_s  fetch,
  output var sasw_data_s   data,
  output var sasw_irq_s    irq
);
  initial begin
    fetch = '0;
    data  = '0;
    irq   = '0;
  end
  // Kind 0 fetch, 1 data, 2 irq; irq packs num, fp flags in a[4:0], a[9:8]
  task automatic go(input int w, input sasw_fkind_e k, input logic g,
                    input logic [31:0] a);
    @(posedge pclk);
    fetch <= '{w == 0, k, g, a};
    data  <= '{w == 1, a};
    irq   <= '{w == 2, a[4:0], a[8], a[9]};
    @(posedge pclk);
    fetch <= '{1'b0, k, ~g, ~a};
    data  <= '{1'b0, ~a};
    irq   <= '{1'b0, ~a[4:0], ~a[8], ~a[9]};
  endtask
endmodule // sasw_cpu_model
`default_nettype wire
